/* hubc_buf.sv */
// Small valid/ready buffer with honest full and empty.
`timescale 1ns/1ps
module hubc_buf #(
    parameter int unsigned W     = 1,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic         clk_i,    // Clock
    input  wire logic         rst_b_i,  // Async reset, active low
    input  wire logic         in_vld_i, // Word offered
    output logic              in_rdy_o, // Room for a word
    input  wire logic [W-1:0] in_dat_i, // Word in
    output logic              out_vld_o, // Word available
    input  wire logic         out_rdy_i, // Drain takes the word
    output logic      [W-1:0] out_dat_o  // Word out, from a register
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign in_rdy_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_vld_o = (cnt_q != '0);
    assign push      = in_vld_i && in_rdy_o;
    assign pop       = out_vld_o && out_rdy_i;
    assign out_dat_o = mem_q[rp_q];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wp_q] <= in_dat_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : hubc_buf

/* hubc_core.sv */
// Eight-station repeater core with local and global routing.
//
// Contract
// - Two modes, local and global, from an external selector set routing.
// - Routing select changes only while the drivers it feeds are disabled (global: the uplink driver; receivers may be on).
// - Heartbeat selector high sends SQE to every station collision output.
// - Control state changes on 10 MHz base clock ticks, 100 ns apart.
// - No station activity or after reset: idle, receive/collision off (global mode: uplink receive activity alone also leaves idle).
// - Local mode ignores uplink inputs and holds uplink outputs inactive.
// - Local: route the active station to all receivers, then enable them.
// - Active station goes quiet: end-of-packet hold, then receivers idle.
// - Local: core makes an SQE burst on the collision outputs of the frame's stations, or all with selector high.
// - Local: second active station gives collision, 10 MHz on all outputs.
// - Local collision: receivers off until all station activity ends.
// - Local collision lasts while any station is active, then idle.
// - Global: idle after reset until uplink or station activity.
// - Global: active station's data goes to the uplink transmit output.
// - Global: station receivers carry only uplink receive data.
// - Global local collision: 5 MHz on uplink transmit output.
// - Global: looped data during local collision signals collision to all.
// - Global: receivers stay on in collision until all activity ends.
// - Global: uplink collision input is passed to all station collision outputs.
// - Global: uplink SQE after a frame reaches all collision outputs.
// - Global: collision held until station and uplink collision end.
// - Global: uplink collision squelch released: 10 MHz on station collisions.
`timescale 1ns/1ps
`include "hubc_regs.svh"
module hubc_core #(
    parameter int unsigned EOP_TICKS = `HUBC_EOP_TICKS,
    parameter int unsigned SQE_GAP   = `HUBC_SQE_GAP_TICKS,
    parameter int unsigned SQE_LEN   = `HUBC_SQE_LEN_TICKS,
    parameter int unsigned BUF_DEPTH = `HUBC_BUF_DEPTH
) (
    input  wire logic                 ref_clk_i,           // 100 MHz clock
    input  wire logic                 rst_b_i,             // Reset, low
    input  wire logic                 mode_global_i,       // 1 global
    input  wire logic                 selective_heartbeat_sel_n_i, // Low sel
    input  wire hubc_pkg::hubc_chan_t station_tx_in_i,     // Station data
    input  wire hubc_pkg::hubc_chan_t station_tx_squelch_i, // 1 quiet
    input  wire logic                 uplink_rx_in_i,      // Loopback data
    input  wire logic                 uplink_rx_squelch_i, // 1 quiet
    input  wire logic                 uplink_col_in_i,     // Collision pair
    input  wire logic                 uplink_col_squelch_i, // 1 quiet
    input  wire logic                 rx_ready_i,          // Drain ready
    output logic                      rx_stall_o,          // Buffer full
    output logic                      station_rx_out_o,    // Receive data
    output logic                      station_rx_en_o,     // Rx drivers on
    output hubc_pkg::hubc_chan_t      station_col_out_o,   // Collision data
    output logic                      station_col_en_o,    // Col drivers on
    output logic                      uplink_tx_out_o,     // Uplink data
    output logic                      uplink_tx_en_o       // Uplink driver
);
    import hubc_pkg::*;

    localparam int unsigned DIV = `HUBC_BASE_DIV;
    localparam int unsigned DW  = $clog2(DIV);
    localparam int unsigned SW  = $clog2(SQE_GAP + SQE_LEN + 1);
    localparam int unsigned HW  = $clog2(EOP_TICKS + 1);
    localparam int unsigned PW  = 2 * `HUBC_NCH + 6;

    // ------------------------------------------------------------------
    // Pin synchronisers and activity decode
    // ------------------------------------------------------------------
    logic [PW-1:0] pin_s;
    hubc_chan_t    tx_s;
    hubc_chan_t    act;
    logic          mode_s;
    logic          seln_s;
    logic          urx_s;
    logic          urx_act;
    logic          ucol_act;
    logic          act_any;
    logic          act_multi;

    hubc_sync #(
        .W (PW)
    ) u_sync (
        .clk_i   (ref_clk_i),
        .rst_b_i (rst_b_i),
        .d_i     ({mode_global_i, selective_heartbeat_sel_n_i,
                   station_tx_in_i, station_tx_squelch_i,
                   uplink_rx_in_i, uplink_rx_squelch_i,
                   uplink_col_in_i, uplink_col_squelch_i}),
        .q_o     (pin_s)
    );

    function automatic hubc_idx_t first_set(input hubc_chan_t v);
        hubc_idx_t r;
        r = '0;
        for (int i = `HUBC_NCH - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = hubc_idx_t'(i);
            end
        end
        return r;
    endfunction : first_set

    function automatic logic many_set(input hubc_chan_t v);
        return (v & (v - 1'b1)) != '0;
    endfunction : many_set

    assign mode_s    = pin_s[PW-1];
    assign seln_s    = pin_s[PW-2];
    assign tx_s      = pin_s[PW-3 -: `HUBC_NCH];
    assign act       = ~pin_s[4 +: `HUBC_NCH];
    assign urx_s     = pin_s[3];
    assign urx_act   = ~pin_s[2];
    // Uplink collision data is not needed: the core makes its own 10 MHz.
    assign ucol_act  = ~pin_s[0];
    assign act_any   = (act != '0);
    assign act_multi = many_set(act);

    // ------------------------------------------------------------------
    // Base clock: 10 MHz tick, 10 MHz and 5 MHz collision waveforms
    // ------------------------------------------------------------------
    logic [DW-1:0] div_q;
    logic          tick;
    logic          clk10;
    logic          clk5_q;

    assign tick  = (div_q == DW'(DIV - 1));
    assign clk10 = (div_q < DW'(DIV / 2));

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_q  <= '0;
            clk5_q <= 1'b0;
        end else begin
            div_q <= tick ? '0 : div_q + 1'b1;
            if (tick) begin
                clk5_q <= ~clk5_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Routing sequencer
    // ------------------------------------------------------------------
    hubc_state_e   st_q;
    hubc_idx_t     sel_q;
    logic          glob_q;
    hubc_chan_t    seen_q;
    logic [HW-1:0] hold_q;
    logic          frame_end;
    logic          local_busy;

    // In global mode the loopback alone keeps a frame alive.
    assign local_busy = act_any || (glob_q && urx_act);
    assign frame_end  = tick && (st_q == ST_ROUTE) && !act_multi
                        && !local_busy;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q   <= ST_IDLE;
            sel_q  <= '0;
            glob_q <= 1'b0;
            seen_q <= '0;
            hold_q <= '0;
        end else if (tick) begin
            case (st_q)
                ST_IDLE: begin
                    glob_q <= mode_s;
                    seen_q <= act;
                    if (act_any || (mode_s && urx_act)) begin
                        sel_q <= first_set(act);
                        st_q  <= act_multi ? ST_COLL : ST_ROUTE;
                    end
                end
                ST_ROUTE: begin
                    seen_q <= seen_q | act;
                    // Global frames may start from the uplink; pick the
                    // station only while its uplink driver is still off.
                    if (glob_q && !uplink_tx_en_o && act_any) begin
                        sel_q <= first_set(act);
                    end
                    if (act_multi) begin
                        st_q <= ST_COLL;
                    end else if (!local_busy) begin
                        st_q   <= ST_HOLD;
                        hold_q <= HW'(EOP_TICKS - 1);
                    end
                end
                ST_HOLD: begin
                    if (hold_q == '0) begin
                        st_q <= ST_IDLE;
                    end else begin
                        hold_q <= hold_q - 1'b1;
                    end
                end
                ST_COLL: begin
                    seen_q <= seen_q | act;
                    if (!glob_q && !act_any) begin
                        st_q <= ST_IDLE;
                    end else if (glob_q && !local_busy) begin
                        st_q   <= ST_HOLD;
                        hold_q <= HW'(EOP_TICKS - 1);
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Local heartbeat generator
    // ------------------------------------------------------------------
    logic [SW-1:0] sqe_q;
    hubc_chan_t    sqe_mask_q;
    logic          sqe_on;

    assign sqe_on = (sqe_q != '0) && (sqe_q <= SW'(SQE_LEN));

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sqe_q      <= '0;
            sqe_mask_q <= '0;
        end else if (tick) begin
            if (frame_end && !glob_q) begin
                sqe_q      <= SW'(SQE_GAP + SQE_LEN);
                sqe_mask_q <= seln_s ? '1 : (seen_q | act);
            end else if (sqe_q != '0) begin
                sqe_q <= sqe_q - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Global collision presence
    // ------------------------------------------------------------------
    logic gcol_q;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gcol_q <= 1'b0;
        end else if (tick) begin
            gcol_q <= glob_q && (ucol_act
                      || (st_q == ST_COLL && urx_act)
                      || (gcol_q && act_any));
        end
    end

    // ------------------------------------------------------------------
    // Receive data path through the buffer
    // ------------------------------------------------------------------
    logic rx_on;
    logic smp_q;
    logic smp_v_q;
    logic in_rdy;
    logic out_vld;
    logic out_dat;

    // Local collisions switch the receivers off to save drive power.
    assign rx_on = glob_q ? (st_q != ST_IDLE)
                          : (st_q == ST_ROUTE || st_q == ST_HOLD);

    // The sample waits when the buffer is full, so the held bit is not dropped.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            smp_q   <= 1'b0;
            smp_v_q <= 1'b0;
        end else if (!smp_v_q || in_rdy) begin
            smp_q   <= glob_q ? urx_s : tx_s[sel_q];
            smp_v_q <= rx_on;
        end
    end

    hubc_buf #(
        .W     (1),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk_i     (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .in_vld_i  (smp_v_q),
        .in_rdy_o  (in_rdy),
        .in_dat_i  (smp_q),
        .out_vld_o (out_vld),
        .out_rdy_i (rx_ready_i),
        .out_dat_o (out_dat)
    );

    // ------------------------------------------------------------------
    // Output drivers
    // ------------------------------------------------------------------
    logic col_loc;

    assign col_loc = !glob_q && (st_q == ST_COLL);

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_stall_o        <= 1'b0;
            station_rx_out_o  <= 1'b0;
            station_rx_en_o   <= 1'b0;
            station_col_out_o <= '0;
            station_col_en_o  <= 1'b0;
            uplink_tx_out_o   <= 1'b0;
            uplink_tx_en_o    <= 1'b0;
        end else begin
            rx_stall_o      <= !in_rdy;
            station_rx_en_o <= rx_on;
            if (out_vld && rx_ready_i) begin
                station_rx_out_o <= out_dat;
            end
            station_col_en_o <= col_loc || gcol_q
                                || (!glob_q && sqe_on);
            if (col_loc || gcol_q) begin
                station_col_out_o <= {`HUBC_NCH{clk10}};
            end else if (!glob_q && sqe_on) begin
                station_col_out_o <= clk10 ? sqe_mask_q : '0;
            end else begin
                station_col_out_o <= '0;
            end
            uplink_tx_en_o  <= glob_q && act_any
                               && (st_q == ST_ROUTE || st_q == ST_COLL);
            uplink_tx_out_o <= glob_q && ((st_q == ST_COLL) ? clk5_q
                                          : tx_s[sel_q]);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    base_tick_a: assert property ($changed(st_q) |-> $past(tick))
        else $error("state moved between base ticks");
    idle_drv_off_a: assert property (
        st_q == ST_IDLE && !sqe_on && !gcol_q
        |=> !station_rx_en_o && !station_col_en_o)
        else $error("drivers on while idle");
    local_no_uplink_a: assert property (
        !glob_q |=> !uplink_tx_en_o && !uplink_tx_out_o)
        else $error("uplink driven in local mode");
    mux_stable_a: assert property (
        $changed(sel_q) |-> !$past(uplink_tx_en_o)
        && ($past(glob_q) || !$past(station_rx_en_o)))
        else $error("routing changed with drivers on");
    coll_rx_off_a: assert property (
        col_loc |=> !station_rx_en_o && station_col_en_o)
        else $error("receivers on during local collision");
    coll_tone_a: assert property (
        col_loc |=> station_col_out_o == {`HUBC_NCH{$past(clk10)}})
        else $error("collision tone wrong");
    eop_hold_a: assert property (
        tick && st_q == ST_HOLD && hold_q == '0 |=> st_q == ST_IDLE)
        else $error("hold did not end");
    hold_len_a: assert property (
        frame_end |=> hold_q == HW'(EOP_TICKS - 1) && st_q == ST_HOLD)
        else $error("hold length wrong");
    sqe_all_a: assert property (
        frame_end && !glob_q && seln_s |=> sqe_mask_q == '1)
        else $error("heartbeat not sent to all");
    glob_five_a: assert property (
        glob_q && st_q == ST_COLL && act_any
        |=> uplink_tx_en_o && uplink_tx_out_o == $past(clk5_q))
        else $error("no 5 MHz on uplink");
    glob_col_a: assert property (
        tick && gcol_q && act_any && glob_q |=> gcol_q ##1 station_col_en_o)
        else $error("global collision dropped early");

    local_route_c: cover property (st_q == ST_ROUTE && !glob_q ##1
                                   st_q == ST_HOLD);
    local_coll_c: cover property (col_loc);
    glob_coll_c: cover property (gcol_q && glob_q);
    sqe_c: cover property (sqe_on && !glob_q);
endmodule : hubc_core

/* hubc_pkg.sv */
// Types shared by the station repeater core files.
`include "hubc_regs.svh"
package hubc_pkg;
    typedef logic [`HUBC_NCH-1:0] hubc_chan_t;
    typedef logic [2:0]           hubc_idx_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ROUTE,
        ST_HOLD,
        ST_COLL
    } hubc_state_e;
endpackage : hubc_pkg

/* hubc_regs.svh */
// Timing counts and sizes of the station repeater core.
`ifndef HUBC_REGS_SVH
`define HUBC_REGS_SVH

// Number of station channels.
`define HUBC_NCH            8
// Reference clock and base clock periods, in ns.
`define HUBC_REF_PERIOD_NS  10
`define HUBC_BASE_PERIOD_NS 100
// Reference cycles in one base clock period.
`define HUBC_BASE_DIV       (`HUBC_BASE_PERIOD_NS / `HUBC_REF_PERIOD_NS)
// End-of-packet hold, in base clock periods.
`define HUBC_EOP_TICKS      8
// Heartbeat gap after a frame and heartbeat length, in base periods.
`define HUBC_SQE_GAP_TICKS  6
`define HUBC_SQE_LEN_TICKS  10
// Depth of the receive data buffer.
`define HUBC_BUF_DEPTH      2

`endif

/* hubc_sync.sv */
// Two flip-flop synchroniser for a bundle of pin levels.
`timescale 1ns/1ps
module hubc_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_i,    // Clock
    input  wire logic         rst_b_i,  // Async reset, active low
    input  wire logic [W-1:0] d_i,      // Asynchronous levels
    output logic      [W-1:0] q_o       // Synchronised levels
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule : hubc_sync

/* hubc_xcvr_model.sv */
// Backbone transceiver model: loopback, heartbeat and forced collisions.
`timescale 1ns/1ps
module hubc_xcvr_model #(
    parameter int unsigned SQE_WAIT = 30,
    parameter int unsigned SQE_CYC  = 20
) (
    input  wire logic ref_clk_i, // Clock
    input  wire logic rst_b_i,   // Async reset, active low
    input  wire logic tx_dat_i,  // Uplink transmit data
    input  wire logic tx_en_i,   // Uplink driver enable
    input  wire logic col_cmd_i, // Bench orders a backbone collision
    input  wire logic rmt_en_i,  // Bench orders remote traffic
    input  wire logic rmt_dat_i, // Remote traffic data level
    output logic      rx_dat_o,  // Looped-back data
    output logic      rx_sq_o,   // Receive squelch, 1 quiet
    output logic      col_dat_o, // Collision pair data
    output logic      col_sq_o   // Collision squelch, 1 quiet
);
    logic        en_q;
    int unsigned cnt_q;
    // A quiet pair holds no level, so it toggles to expose stale reads.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            en_q      <= 1'b0;
            rx_dat_o  <= 1'b0;
            rx_sq_o   <= 1'b1;
            col_dat_o <= 1'b0;
        end else begin
            en_q      <= tx_en_i;
            rx_dat_o  <= tx_en_i  ? tx_dat_i
                       : rmt_en_i ? rmt_dat_i : ~rx_dat_o;
            rx_sq_o   <= ~(tx_en_i || rmt_en_i);
            col_dat_o <= ~col_dat_o;
        end
    end
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= 0;
        end else if (en_q && !tx_en_i) begin
            cnt_q <= SQE_WAIT + SQE_CYC;
        end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
    assign col_sq_o = !(col_cmd_i
                        || (cnt_q != 0 && cnt_q <= SQE_CYC));
endmodule : hubc_xcvr_model

/* tb_top.sv */
// Self-checking bench of the station repeater core.
`timescale 1ns/1ps
module tb_top;
    import hubc_pkg::*;
    typedef struct {
        logic [1:0] k;
        logic       d;
        hubc_chan_t m;
    } hubc_note_s;
    logic        ref_clk_i = 1'b0;
    logic        rst_b_i   = 1'b0;
    logic        mode_q    = 1'b0;
    logic        sel_n_q   = 1'b1;
    logic        rdy_q     = 1'b1;
    logic        cmd_q     = 1'b0;
    logic        rmt_q     = 1'b0;
    logic        rbit_q    = 1'b0;
    hubc_chan_t  dat_q     = '0;
    hubc_chan_t  sq_q      = '1;
    hubc_chan_t  col_out;
    logic        urx, ursq, ucol, ucsq, stall, rxo, rxe, cole, utx, utxe;
    int          n_fail    = 0;
    int          compares  = 0;
    int          cyc       = 0;
    logic [31:0] seed      = 32'hae72_c4e2;
    hubc_note_s  notes[$];

    always #5 ref_clk_i = ~ref_clk_i;

    hubc_core #(.EOP_TICKS(2), .SQE_GAP(3), .SQE_LEN(2)) DUT (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .mode_global_i(mode_q),
        .selective_heartbeat_sel_n_i(sel_n_q), .station_tx_in_i(dat_q),
        .station_tx_squelch_i(sq_q), .uplink_rx_in_i(urx),
        .uplink_rx_squelch_i(ursq), .uplink_col_in_i(ucol),
        .uplink_col_squelch_i(ucsq), .rx_ready_i(rdy_q), .rx_stall_o(stall),
        .station_rx_out_o(rxo), .station_rx_en_o(rxe),
        .station_col_out_o(col_out), .station_col_en_o(cole),
        .uplink_tx_out_o(utx), .uplink_tx_en_o(utxe));
    hubc_xcvr_model #(.SQE_WAIT(30), .SQE_CYC(20)) xcvr (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .tx_dat_i(utx),
        .tx_en_i(utxe), .col_cmd_i(cmd_q), .rmt_en_i(rmt_q),
        .rmt_dat_i(rbit_q), .rx_dat_o(urx), .rx_sq_o(ursq),
        .col_dat_o(ucol), .col_sq_o(ucsq));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    task automatic clks(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : clks
    task automatic drive(input hubc_chan_t sq, input hubc_chan_t d);
        @(posedge ref_clk_i);
        sq_q  <= sq;
        dat_q <= d;
    endtask : drive
    task automatic wait_for(input int w, input logic lvl, output int n);
        n = 0;
        while ((w == 0 ? rxe : cole) !== lvl && n < 300) begin
            @(negedge ref_clk_i);
            n++;
        end
    endtask : wait_for
    task automatic frame(input int st, input logic glob);
        int         n;
        logic       b;
        hubc_chan_t one;
        one = hubc_chan_t'(1) << st;
        b = 1'(rnd());
        notes.push_back('{2'b10, b, '0});
        if (glob) begin
            notes.push_back('{2'b01, 1'b0, '1});
        end
        notes.push_back('{2'b01, 1'b0, (glob || sel_n_q) ? '1 : one});
        drive(~one, {8{b}});
        wait_for(0, 1'b1, n);
        check(8'(n < 40), 8'd1);
        clks(14);
        check({6'd0, utxe, utx}, {6'd0, glob, glob & b});
        @(posedge ref_clk_i);
        cmd_q <= 1'b1;
        clks(20);
        check(8'(cole), 8'(glob));
        @(posedge ref_clk_i);
        cmd_q <= 1'b0;
        rdy_q <= 1'b0;
        clks(20);
        check({6'd0, cole, stall}, {6'd0, glob, 1'b1});
        @(posedge ref_clk_i);
        rdy_q <= 1'b1;
        clks(4);
        check(8'(stall), 8'd0);
        drive('1, '0);
        wait_for(0, 1'b0, n);
        if (!glob) begin
            check(8'(n >= 20 && n <= 45), 8'd1);
        end
        wait_for(1, 1'b1, n);
        check(8'(n < 300), 8'd1);
        wait_for(1, 1'b0, n);
        clks(30);
    endtask : frame
    task automatic coll(input logic glob);
        int   st, s2, n;
        logic b;
        st = int'(rnd() % 8);
        s2 = (st + 1 + int'(rnd() % 7)) % 8;
        notes.push_back('{2'b10, 1'b1, '0});
        notes.push_back('{2'b01, 1'b0, '1});
        if (glob) begin
            notes.push_back('{2'b01, 1'b0, '1});
        end
        drive(~(hubc_chan_t'(1) << st), '1);
        wait_for(0, 1'b1, n);
        clks(14);
        drive(~((hubc_chan_t'(1) << st) | (hubc_chan_t'(1) << s2)), '1);
        wait_for(1, 1'b1, n);
        check(8'(n < 60), 8'd1);
        b = utx;
        clks(10);
        check(8'(utx ^ b), 8'(glob));
        check(8'(rxe), 8'(glob));
        drive(~(hubc_chan_t'(1) << st), '1);
        clks(30);
        check(8'(cole), 8'd1);
        drive('1, '0);
        wait_for(1, 1'b0, n);
        check(8'(n < 60), 8'd1);
        wait_for(0, 1'b0, n);
        if (glob) begin
            wait_for(1, 1'b1, n);
            wait_for(1, 1'b0, n);
        end
        clks(60);
    endtask : coll

    // ------------------------------------------------------------
    // Processes
    // ------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    // Every rise of a driver enable takes the oldest note off the queue.
    initial begin : monitor
        hubc_note_s nt;
        logic       pr, pc;
        hubc_chan_t c0;
        pr = 1'b0;
        pc = 1'b0;
        forever begin
            @(negedge ref_clk_i);
            if ((rxe === 1'b1 && !pr) || (cole === 1'b1 && !pc)) begin
                if (notes.size() > 0) begin
                    nt = notes.pop_front();
                end else begin
                    nt = '{2'b11, 1'b0, '0};
                end
                check({6'd0, rxe & ~pr, cole & ~pc}, {6'd0, nt.k});
                c0 = col_out;
                if (nt.k[0]) begin
                    check(col_out & ~nt.m, '0);
                    clks(5);
                    check(col_out ^ c0, nt.m);
                end else begin
                    clks(12);
                    check(8'(rxo), 8'(nt.d));
                end
            end
            pr = rxe;
            pc = cole;
        end
    end
    initial begin : main
        logic rb;
        int   n;
        repeat (6) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        clks(2);
        check(8'({rxe, cole, utxe, stall}), 8'd0);
        for (int k = 0; k < 2; k++) begin
            @(posedge ref_clk_i);
            sel_n_q <= (k == 0);
            clks(10);
            frame(int'(rnd() % 8), 1'b0);
        end
        coll(1'b0);
        @(posedge ref_clk_i);
        mode_q <= 1'b1;
        clks(40);
        frame(int'(rnd() % 8), 1'b1);
        coll(1'b1);
        // Remote traffic alone: stations carry the inverse, so a direct
        // station path would show up on the receive data.
        rb = 1'(rnd());
        notes.push_back('{2'b10, rb, '0});
        @(posedge ref_clk_i);
        rbit_q <= rb;
        rmt_q  <= 1'b1;
        dat_q  <= {8{~rb}};
        wait_for(0, 1'b1, n);
        check(8'(n < 40 && utxe === 1'b0), 8'd1);
        clks(30);
        @(posedge ref_clk_i);
        rmt_q <= 1'b0;
        wait_for(0, 1'b0, n);
        check(8'(n < 60), 8'd1);
        clks(20);
        check(8'(notes.size()), 8'd0);
        give_verdict();
    end
endmodule : tb_top
